// *** hw/cache_control.sv ***
// Second-level cache control register with strap-loaded size and SRAM type fields.
//
// Contract
// - Read/write control byte at offset 52h; resets to strap nibble over 0010.
// - After hard reset, bits 7:4 take the inverted address strap pins 31:28.
// - Size field bits 7:6 take inverted pins 31:30 at the sixth clock after reset releases.
// - Later software writes replace the strapped size and govern operation.
// - Size code 00 none, 01 256 Kbytes, 10 512 Kbytes, 11 reserved.
// - Size code 00 disables the cache and freezes all tag state.
// - Cache runs only with nonzero size and the enable bit set.
// - SRAM type bits 5:4 take inverted pins 29:28; writes may replace them.
// - Type 00 pipelined, 01 burst, 10 async, 11 dual-bank with turnaround.
`timescale 1ns/1ns
module cache_control (
  input  wire logic                    clk_i,          // 20 MHz system clock.
  input  wire logic                    rstn_i,         // Hard reset, active low.
  input  cache_ctl_pkg::reg_req_s      req_i,          // Register bus request.
  input  wire logic [3:0]              strap_addr_i,   // Address pins 31:28 as straps.
  input  wire logic                    cache_enable_i, // Separate cache enable bit.
  output logic      [7:0]              rdata_o,        // Read data, cycle after read.
  output cache_ctl_pkg::cache_cfg_s    cfg_o,          // Decoded cache configuration.
  output logic                         strap_done_o    // High once straps are loaded.
);

  typedef struct packed {
    cache_ctl_pkg::strap_st_e  st;
    logic [2:0]                cnt;
    logic [7:0]                cc;
    logic [7:0]                rdata;
    cache_ctl_pkg::cache_cfg_s cfg;
    logic                      done;
  } ctl_state_s;

  localparam ctl_state_s STATE_RST = '{
    st:    cache_ctl_pkg::ST_SETTLE,
    cnt:   cache_ctl_pkg::STRAP_SETTLE_CYC,
    cc:    cache_ctl_pkg::CACHE_CONTROL_RST,
    rdata: 8'h00,
    cfg:   cache_ctl_pkg::CFG_RST,
    done:  1'b0
  };

  ctl_state_s                s_r;
  ctl_state_s                s_nxt;
  logic [3:0]                strap_val;
  cache_ctl_pkg::cache_cfg_s cfg_nxt;
  logic                      hit;
  logic                      wr_hit;

  // Strap pins come from outside the clock domain and are filtered first.
  strap_sync #(
    .W (cache_ctl_pkg::STRAP_W)
  ) u_strap_sync (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .pin_i  (strap_addr_i),
    .val_o  (strap_val)
  );

  // Decode the value the control byte takes at the next edge, so that the
  // configuration output changes at the same edge as the register itself.
  cache_cfg_decode u_decode (
    .cc_i     (s_nxt.cc),
    .enable_i (cache_enable_i),
    .cfg_o    (cfg_nxt)
  );

  // Only the one mapped offset answers; other offsets read as zero and ignore writes.
  assign hit    = (req_i.addr == cache_ctl_pkg::CACHE_CONTROL_OFS);
  assign wr_hit = req_i.wr && hit && (s_r.st == cache_ctl_pkg::ST_RUN);

  always_comb
  begin
    s_nxt       = s_r;
    s_nxt.rdata = 8'h00;
    unique case (s_r.st)
      cache_ctl_pkg::ST_SETTLE:
      begin
        // Wait until the synchroniser holds the levels present at release.
        if (s_r.cnt == 3'h0)
        begin
          s_nxt.st = cache_ctl_pkg::ST_LOAD;
        end
        else
        begin
          s_nxt.cnt = s_r.cnt - 3'h1;
        end
      end
      cache_ctl_pkg::ST_LOAD:
      begin
        // Only the upper nibble takes the straps; the lower nibble keeps its reset pattern.
        s_nxt.cc[cache_ctl_pkg::SIZE_MSB:cache_ctl_pkg::SIZE_LSB] = ~strap_val[3:2];
        s_nxt.cc[cache_ctl_pkg::TYPE_MSB:cache_ctl_pkg::TYPE_LSB] = ~strap_val[1:0];
        s_nxt.st   = cache_ctl_pkg::ST_RUN;
        s_nxt.done = 1'b1;
      end
      cache_ctl_pkg::ST_RUN:
      begin
        // Writes are taken only after the load, so the load can never overwrite them.
        if (wr_hit)
        begin
          s_nxt.cc = req_i.wdata;
        end
      end
      default:
      begin
        s_nxt = STATE_RST;
      end
    endcase
    // Reads return the stored byte; unmapped addresses read as zero.
    if (req_i.rd && hit)
    begin
      s_nxt.rdata = s_r.cc;
    end
    s_nxt.cfg = cfg_nxt;
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      s_r <= STATE_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign rdata_o      = s_r.rdata;
  assign cfg_o        = s_r.cfg;
  assign strap_done_o = s_r.done;

  default clocking cb @(posedge clk_i);
  endclocking

  default disable iff (!rstn_i);

  // Lower nibble holds its reset pattern while the straps settle.
  reset_nibble_a: assert property (
    (s_r.st == cache_ctl_pkg::ST_SETTLE) |-> (s_r.cc == cache_ctl_pkg::CACHE_CONTROL_RST)
  ) else $error("control byte left its reset value before the strap load");

  // A read of the mapped offset returns the byte in the next cycle.
  read_back_a: assert property (
    (req_i.rd && hit) |=> (rdata_o == $past(s_r.cc))
  ) else $error("read data does not match the stored control byte");

  // Unmapped reads and idle cycles show zero.
  read_zero_a: assert property (
    !(req_i.rd && hit) |=> (rdata_o == 8'h00)
  ) else $error("read data not zero outside a mapped read");

  // The upper nibble is the inverse of the filtered strap levels.
  strap_nibble_a: assert property (
    (s_r.st == cache_ctl_pkg::ST_LOAD) |=> (s_r.cc[7:4] == ~$past(strap_val))
  ) else $error("upper nibble is not the inverted strap levels");

  // Size field equals inverted pins 31:30.
  size_strap_a: assert property (
    (s_r.st == cache_ctl_pkg::ST_LOAD) |=> (s_r.cc[7:6] == ~$past(strap_val[3:2]))
  ) else $error("size field not loaded from inverted strap pins");

  // SRAM type field equals inverted pins 29:28.
  type_strap_a: assert property (
    (s_r.st == cache_ctl_pkg::ST_LOAD) |=> (s_r.cc[5:4] == ~$past(strap_val[1:0]))
  ) else $error("SRAM type field not loaded from inverted strap pins");

  // A write after the load replaces the whole byte and its decode.
  write_takes_a: assert property (
    wr_hit |=> ((s_r.cc == $past(req_i.wdata))
                && (cfg_o.tag_freeze == ($past(req_i.wdata[7:6]) == 2'h0)))
  ) else $error("software write did not replace the control byte");

  // Size decode follows the stored code.
  size_decode_a: assert property (
    (cfg_o.size_kb == ((s_r.cc[7:6] == 2'h1) ? cache_ctl_pkg::SIZE_256_KB :
                       (s_r.cc[7:6] == 2'h2) ? cache_ctl_pkg::SIZE_512_KB :
                                               cache_ctl_pkg::SIZE_NONE_KB))
  ) else $error("cache size decode wrong");

  // A zero size field disables the cache and freezes the tags.
  freeze_a: assert property (
    (s_r.cc[7:6] == 2'h0) |-> (cfg_o.tag_freeze && !cfg_o.l2_on)
  ) else $error("cache not frozen with zero size field");

  // The cache runs only with a nonzero size and the enable bit set.
  enable_gate_a: assert property (
    cfg_o.l2_on |-> ((s_r.cc[7:6] != 2'h0) && $past(cache_enable_i))
  ) else $error("cache enabled without size or enable bit");

  // Dual-bank type asks for a turnaround clock and requires the 512 Kbyte size.
  dual_bank_a: assert property (
    (s_r.cc[5:4] == 2'h3) |->
      (cfg_o.turnaround && (cfg_o.cfg_err == (s_r.cc[7:6] != 2'h2)))
  ) else $error("dual-bank type decode wrong");

  sequence load_step_s;
    s_r.st == cache_ctl_pkg::ST_LOAD;
  endsequence

  sequence run_hold_s;
    ((s_r.st == cache_ctl_pkg::ST_RUN) && strap_done_o) [*3];
  endsequence

  property boot_order_p;
    load_step_s |=> run_hold_s;
  endproperty

  // The strap load happens once and is followed by normal operation.
  boot_order_a: assert property (boot_order_p)
    else $error("strap load not followed by run state");

  // In normal operation the byte changes only through a write.
  no_resample_a: assert property (
    ((s_r.st == cache_ctl_pkg::ST_RUN) && !wr_hit) |=> $stable(s_r.cc)
  ) else $error("control byte changed without a write");

  sequence settle_tick_s;
    (s_r.st == cache_ctl_pkg::ST_SETTLE) && (s_r.cnt != 3'h0);
  endsequence

  sequence settle_end_s;
    (s_r.st == cache_ctl_pkg::ST_SETTLE) && (s_r.cnt == 3'h0);
  endsequence

  // The settle window counts down by one per clock.
  settle_count_a: assert property (
    settle_tick_s |=> ((s_r.st == cache_ctl_pkg::ST_SETTLE)
                       && (s_r.cnt == ($past(s_r.cnt) - 3'h1)))
  ) else $error("settle counter did not step down");

  // The end of the settle window leads straight to the strap load.
  settle_exit_a: assert property (
    settle_end_s |=> load_step_s
  ) else $error("settle window did not end in the strap load");

  // The load comes a fixed number of clocks after reset is released.
  settle_time_a: assert property (
    ((s_r.st == cache_ctl_pkg::ST_SETTLE) && (s_r.cnt == cache_ctl_pkg::STRAP_SETTLE_CYC))
      |-> ##5 load_step_s
  ) else $error("strap load not at the expected clock");

  // The strap load leaves the lower nibble alone.
  load_low_keep_a: assert property (
    (s_r.st == cache_ctl_pkg::ST_LOAD) |=> (s_r.cc[3:0] == $past(s_r.cc[3:0]))
  ) else $error("strap load disturbed the lower nibble");

  // A write sets the SRAM type field from the written byte.
  type_write_a: assert property (
    wr_hit |=> ((s_r.cc[5:4] == $past(req_i.wdata[5:4]))
                && (cfg_o.sram == $past(req_i.wdata[5:4])))
  ) else $error("SRAM type field not replaced by a write");

  // Writes to other offsets leave the byte alone.
  unmapped_write_a: assert property (
    (req_i.wr && !hit && (s_r.st == cache_ctl_pkg::ST_RUN)) |=> $stable(s_r.cc)
  ) else $error("control byte changed by a write to another offset");

  // Writes that arrive before the strap load are dropped.
  early_write_a: assert property (
    (req_i.wr && hit && (s_r.st == cache_ctl_pkg::ST_SETTLE))
      |=> (s_r.cc == cache_ctl_pkg::CACHE_CONTROL_RST)
  ) else $error("write taken before the strap load");

  // Once the load is done the block stays in normal operation until reset.
  run_stays_a: assert property (
    (s_r.st == cache_ctl_pkg::ST_RUN) |=> (s_r.st == cache_ctl_pkg::ST_RUN)
  ) else $error("left normal operation without reset");

  // The done flag stays high until the next hard reset.
  done_hold_a: assert property (
    strap_done_o |=> strap_done_o
  ) else $error("strap done flag dropped without reset");

  // The SRAM type code is passed through unchanged.
  sram_decode_a: assert property (
    cfg_o.sram == s_r.cc[5:4]
  ) else $error("SRAM type decode wrong");

  // Only the dual-bank type asks for the turnaround clock.
  turnaround_off_a: assert property (
    (s_r.cc[5:4] != 2'h3) |-> !cfg_o.turnaround
  ) else $error("turnaround set for a single-bank type");

  // The reserved size code flags an error and keeps the cache off.
  rsvd_size_a: assert property (
    (s_r.cc[7:6] == 2'h3) |-> (cfg_o.cfg_err && !cfg_o.l2_on && !cfg_o.tag_freeze)
  ) else $error("reserved size code decode wrong");

  // A nonzero size code never freezes the tags.
  freeze_off_a: assert property (
    (s_r.cc[7:6] != 2'h0) |-> !cfg_o.tag_freeze
  ) else $error("tags frozen with a nonzero size field");

  // A valid size with the enable bit set turns the cache on.
  enable_on_a: assert property (
    (((s_r.cc[7:6] == 2'h1) || (s_r.cc[7:6] == 2'h2)) && $past(cache_enable_i))
      |-> cfg_o.l2_on
  ) else $error("cache off with a valid size and the enable bit set");

endmodule : cache_control

// *** hw/cache_ctl_pkg.sv ***
// Shared constants, types and carriers of the second-level cache control register.
package cache_ctl_pkg;

  localparam logic [7:0] CACHE_CONTROL_OFS = 8'h52;
  localparam logic [7:0] CACHE_CONTROL_RST = 8'h02;

  localparam int         SIZE_MSB          = 7;
  localparam int         SIZE_LSB          = 6;
  localparam int         TYPE_MSB          = 5;
  localparam int         TYPE_LSB          = 4;
  localparam int         STRAP_MSB         = 7;
  localparam int         STRAP_LSB         = 4;
  localparam int         STRAP_W           = 4;

  localparam logic [2:0] STRAP_SETTLE_CYC  = 3'h4;

  localparam logic [9:0] SIZE_NONE_KB      = 10'h000;
  localparam logic [9:0] SIZE_256_KB       = 10'h100;
  localparam logic [9:0] SIZE_512_KB       = 10'h200;

  typedef enum logic [1:0] {
    L2_SIZE_NONE = 2'h0,
    L2_SIZE_256K = 2'h1,
    L2_SIZE_512K = 2'h2,
    L2_SIZE_RSVD = 2'h3
  } l2_size_e;

  typedef enum logic [1:0] {
    SRAM_PIPE_BURST = 2'h0,
    SRAM_BURST      = 2'h1,
    SRAM_ASYNC      = 2'h2,
    SRAM_DUAL_BANK  = 2'h3
  } sram_type_e;

  typedef enum logic [2:0] {
    ST_SETTLE = 3'b001,
    ST_LOAD   = 3'b010,
    ST_RUN    = 3'b100
  } strap_st_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_s;

  typedef struct packed {
    logic       l2_on;
    logic       tag_freeze;
    logic [9:0] size_kb;
    sram_type_e sram;
    logic       turnaround;
    logic       cfg_err;
  } cache_cfg_s;

  localparam cache_cfg_s CFG_RST = '{
    l2_on:      1'b0,
    tag_freeze: 1'b1,
    size_kb:    SIZE_NONE_KB,
    sram:       SRAM_PIPE_BURST,
    turnaround: 1'b0,
    cfg_err:    1'b0
  };

endpackage : cache_ctl_pkg

// *** hw/strap_sync.sv ***
// Three-stage synchroniser for the strap pins with an agreement filter.
`timescale 1ns/1ns
module strap_sync #(
  parameter int W = 4
) (
  input  wire logic         clk_i,   // System clock.
  input  wire logic         rstn_i,  // Asynchronous reset, active low.
  input  wire logic [W-1:0] pin_i,   // Raw pin levels.
  output logic      [W-1:0] val_o    // Filtered, synchronised levels.
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] val;
  } sync_s;

  sync_s s_r;
  sync_s s_nxt;

  // The first stage feeds only the second; the filter looks at stages two and three.
  always_comb
  begin
    s_nxt    = s_r;
    s_nxt.s1 = pin_i;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    if (s_r.s2 == s_r.s3)
    begin
      s_nxt.val = s_r.s3;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign val_o = s_r.val;

endmodule : strap_sync

// *** hw/cache_cfg_decode.sv ***
// Combinational decode of the cache control byte into cache configuration.
`timescale 1ns/1ns
module cache_cfg_decode (
  input  wire logic [7:0]              cc_i,      // Cache control byte.
  input  wire logic                    enable_i,  // Separate cache enable bit.
  output cache_ctl_pkg::cache_cfg_s    cfg_o      // Decoded configuration.
);

  function automatic logic [9:0] size_kb(input logic [1:0] code);
    unique case (code)
      cache_ctl_pkg::L2_SIZE_256K: size_kb = cache_ctl_pkg::SIZE_256_KB;
      cache_ctl_pkg::L2_SIZE_512K: size_kb = cache_ctl_pkg::SIZE_512_KB;
      default:                     size_kb = cache_ctl_pkg::SIZE_NONE_KB;
    endcase
  endfunction : size_kb

  logic [1:0] size_code;
  logic [1:0] type_code;

  always_comb
  begin
    size_code        = cc_i[cache_ctl_pkg::SIZE_MSB:cache_ctl_pkg::SIZE_LSB];
    type_code        = cc_i[cache_ctl_pkg::TYPE_MSB:cache_ctl_pkg::TYPE_LSB];
    cfg_o.size_kb    = size_kb(size_code);
    cfg_o.tag_freeze = (size_code == cache_ctl_pkg::L2_SIZE_NONE);
    cfg_o.l2_on      = (size_code != cache_ctl_pkg::L2_SIZE_NONE)
                       && (size_code != cache_ctl_pkg::L2_SIZE_RSVD)
                       && enable_i;
    cfg_o.sram       = cache_ctl_pkg::sram_type_e'(type_code);
    cfg_o.turnaround = (type_code == cache_ctl_pkg::SRAM_DUAL_BANK);
    cfg_o.cfg_err    = (size_code == cache_ctl_pkg::L2_SIZE_RSVD)
                       || (cfg_o.turnaround
                           && (size_code != cache_ctl_pkg::L2_SIZE_512K));
  end

endmodule : cache_cfg_decode

// *** test/strap_pullups.sv ***
// Behavioural model of the strap resistors on host address pins 31:28.
`timescale 1ns/1ns
module strap_pullups (
  input  wire logic       clk_i,   // System clock.
  input  wire logic       hold_i,  // High while the board holds the strap levels.
  input  wire logic [3:0] level_i, // Levels fitted on the board.
  output logic      [3:0] pin_o    // Levels seen on the pins.
);
  // Once reset is over the pins carry bus traffic, so a changing pattern stands in for it.
  always_ff @(posedge clk_i)
  begin
    if (hold_i)
      pin_o <= level_i;
    else
      pin_o <= ~pin_o;
  end
endmodule : strap_pullups

// *** test/test_cache_control.sv ***
// Self-checking bench of the cache control register.
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
  begin \
    checks++; \
    if ((got) !== (ex)) \
    begin \
      errors++; \
      $display("CHECK FAILED %s exp %h got %h", nm, ex, got); \
    end \
  end
module test_cache_control;
  logic                      clk;
  logic                      rstn;
  cache_ctl_pkg::reg_req_s   req;
  logic                      hold;
  logic                [3:0] level;
  logic                [3:0] strap;
  logic                      en;
  logic                [7:0] rdata;
  cache_ctl_pkg::cache_cfg_s cfg;
  logic                      done;
  int                        errors;
  int                        checks;

  strap_pullups i_strap_pullups (.clk_i(clk), .hold_i(hold), .level_i(level), .pin_o(strap));

  cache_control i_cache_control (
    .clk_i         (clk),
    .rstn_i        (rstn),
    .req_i         (req),
    .strap_addr_i  (strap),
    .cache_enable_i(en),
    .rdata_o       (rdata),
    .cfg_o         (cfg),
    .strap_done_o  (done)
  );

  always #25 clk = ~clk;

  task automatic complete_run;
    if (errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  task automatic check_cfg(input logic [7:0] b, input logic e);
    logic [1:0] sz;
    logic [1:0] ty;
    logic [9:0] kb;
    sz = b[7:6];
    ty = b[5:4];
    kb = (sz == 2'h1) ? cache_ctl_pkg::SIZE_256_KB : cache_ctl_pkg::SIZE_NONE_KB;
    kb = (sz == 2'h2) ? cache_ctl_pkg::SIZE_512_KB : kb;
    @(negedge clk);
    `CHK("size_kb", kb, cfg.size_kb)
    `CHK("l2_on", e && (sz == 2'h1 || sz == 2'h2), cfg.l2_on)
    `CHK("tag_freeze", sz == 2'h0, cfg.tag_freeze)
    `CHK("sram", ty, cfg.sram)
    `CHK("cfg_err", sz == 2'h3 || (ty == 2'h3 && sz != 2'h2), cfg.cfg_err)
    `CHK("turnaround", ty == 2'h3, cfg.turnaround)
  endtask : check_cfg

  task automatic t_strap(input logic [3:0] s);
    logic [7:0] d;
    int         n;
    @(posedge clk);
    rstn <= 1'b0;
    hold <= 1'b1;
    level <= s;
    repeat (5) @(posedge clk);
    `CHK("rst cfg", cache_ctl_pkg::CFG_RST, cfg)
    `CHK("rst done", 1'b0, done)
    `CHK("rst rdata", 8'h00, rdata)
    rstn <= 1'b1;
    // A write inside the settle window must be dropped.
    wr_reg(8'h52, 8'hFF);
    n = 0;
    while (done !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK("done", 1'b1, done)
    @(posedge clk);
    hold <= 1'b0;
    rd_reg(8'h52, d);
    `CHK("strap byte", {~s, 4'h2}, d)
    check_cfg({~s, 4'h2}, en);
  endtask : t_strap

  task automatic t_writes;
    logic [7:0] d;
    logic [7:0] v;
    for (int i = 0; i < 32; i++)
    begin
      v = {i[3:0], ~i[3:0]};
      @(posedge clk);
      en <= i[4];
      wr_reg(8'h52, v);
      rd_reg(8'h52, d);
      `CHK("wr byte", v, d)
      check_cfg(v, i[4]);
    end
  endtask : t_writes

  task automatic t_unmapped;
    logic [7:0] d;
    wr_reg(8'h52, 8'h5A);
    wr_reg(8'h53, 8'hFF);
    rd_reg(8'h53, d);
    `CHK("unmapped rd", 8'h00, d)
    @(posedge clk);
    #1;
    `CHK("rdata idle", 8'h00, rdata)
    repeat (20) @(posedge clk);
    rd_reg(8'h52, d);
    `CHK("kept byte", 8'h5A, d)
  endtask : t_unmapped

  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    req = '0;
    hold = 1'b1;
    level = 4'h0;
    en = 1'b1;
    errors = 0;
    checks = 0;
    t_strap(4'h9);
    t_writes;
    t_unmapped;
    t_strap(4'h2);
    complete_run;
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    errors++;
    complete_run;
  end
endmodule : test_cache_control
